// ==== twr_pkg.sv ====
/*
 * twr_pkg: shared constants of the trigger word recognizer.
 * assumes a 32-bit plain register port with byte-style offsets.
 */
package twr_pkg;

    localparam int unsigned WORD_W    = 24;
    localparam int unsigned SEG_W     = 8;
    localparam int unsigned NUM_SEG   = 3;
    localparam int unsigned NUM_WORDS = 4;
    localparam int unsigned LVL_W     = 4;
    localparam int unsigned LCTL_W    = 4;
    localparam int unsigned ADDR_W    = 8;

    // register offsets
    localparam logic [7:0] OFS_CTL    = 8'h00;
    localparam logic [7:0] OFS_ROLE   = 8'h04;
    localparam logic [7:0] OFS_QRAM   = 8'h08;
    localparam logic [7:0] OFS_SRAM   = 8'h0C;
    localparam logic [7:0] OFS_LCTL   = 8'h10;
    localparam logic [7:0] OFS_PLOAD  = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_RDSEL  = 8'h1C;
    localparam logic [7:0] OFS_RDDATA = 8'h20;

    // control register fields
    localparam int unsigned CTL_INV_LSB   = 0;
    localparam int unsigned CTL_FORCE     = 3;
    localparam int unsigned CTL_ALT_MODE  = 4;
    localparam int unsigned CTL_DUALQ_N   = 5;
    localparam int unsigned CTL_STEPEN_N  = 6;
    localparam int unsigned CTL_STEP_N    = 7;
    localparam int unsigned CTL_W         = 8;
    localparam logic [7:0]  CTL_RESET     = 8'hE0;

    // role register: 2-bit word selectors
    localparam int unsigned ROLE_START = 0;
    localparam int unsigned ROLE_STOP  = 2;
    localparam int unsigned ROLE_GATE  = 4;
    localparam int unsigned ROLE_RESET = 6;
    localparam int unsigned ROLE_ALT   = 8;
    localparam int unsigned ROLE_W     = 10;
    localparam logic [9:0]  ROLE_RESET_VAL = 10'h000;

    // qualifier ram write fields
    localparam int unsigned QRAM_SEG_LSB  = 8;
    localparam int unsigned QRAM_DATA_LSB = 10;
    // sequence ram write fields
    localparam int unsigned SRAM_SEG_LSB  = 12;
    localparam int unsigned SRAM_DATA_BIT = 16;
    // level control ram write fields
    localparam int unsigned LCTL_DATA_LSB = 4;
    localparam int unsigned LCTL_LAST_BIT = 0;
    localparam int unsigned LCTL_POL_BIT  = 3;
    localparam logic [3:0]  LCTL_RESET    = 4'h1;
    // readback selector: [17:16] 0 qram, 1 sram, 2 lctl
    localparam int unsigned RDSEL_KIND_LSB = 16;
    localparam logic [1:0]  RD_QRAM = 2'h0;
    localparam logic [1:0]  RD_SRAM = 2'h1;
    localparam logic [1:0]  RD_LCTL = 2'h2;

    localparam logic [3:0]  LVL_MAX   = 4'hF;
    localparam logic [3:0]  LVL_RESET = 4'h0;

endpackage

// ==== twr_lvl_if.sv ====
/*
 * twr_lvl_if: level pointer control bundle between top and counter.
 * assumes both ends share clk_i.
 */
`timescale 1ns/100ps
interface twr_lvl_if;
    logic       clear;
    logic       load_n;
    logic [3:0] load_val;
    logic       advance;
    logic       last_level_flag;
    logic [3:0] level_pointer;

    modport ctrl (output clear, output load_n, output load_val, output advance,
                  output last_level_flag, input level_pointer);
    modport ptr  (input clear, input load_n, input load_val, input advance,
                  input last_level_flag, output level_pointer);
endinterface

// ==== twr_level_ptr.sv ====
/*
 * twr_level_ptr: four-bit sequence level pointer.
 * assumes advance is a one-cycle pulse synchronous to clk_i.
 */
`timescale 1ns/100ps
module twr_level_ptr
    import twr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic resetn_i,
    twr_lvl_if.ptr    lvl
);
    logic [3:0] ptr_q;
    logic [3:0] ptr_d;
    logic       cnt_en;

    // stop while the last level flag is clear and at all ones
    assign cnt_en = lvl.advance & lvl.last_level_flag & (ptr_q != LVL_MAX);

    always_comb begin
        ptr_d = ptr_q;
        if (lvl.clear) begin
            ptr_d = LVL_RESET;
        end else if (!lvl.load_n) begin
            ptr_d = lvl.load_val;
        end else if (cnt_en) begin
            ptr_d = ptr_q + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ptr_q <= LVL_RESET;
        end else begin
            ptr_q <= ptr_d;
        end
    end

    assign lvl.level_pointer = ptr_q;
endmodule

// ==== twr_top.sv ====
/*
 * twr_top: qualifier and sequence word recognition of an expansion
 * acquisition module, with a plain register port.
 * assumes wired-AND lines are resolved outside from the enables, and
 * all inputs are synchronous to clk_i.
 */
`timescale 1ns/100ps
module twr_top
    import twr_pkg::*;
#(
    parameter int unsigned P_WORD_W    = WORD_W,
    parameter int unsigned P_NUM_WORDS = NUM_WORDS
) (
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    // register port
    input  wire logic [ADDR_W-1:0]    reg_addr_i,
    input  wire logic [31:0]          reg_wdata_i,
    input  wire logic                 reg_we_i,
    input  wire logic                 reg_re_i,
    output logic      [31:0]          reg_rdata_o,
    // acquisition side
    input  wire logic [P_WORD_W-1:0]  acquired_word_bus_i,
    input  wire logic                 level_advance_i,
    input  wire logic                 master_reset_i,
    // wired-AND qualifier lines
    input  wire logic [3:0]           qual_line_i,
    output logic      [3:0]           qual_line_o,
    output logic      [3:0]           qual_line_oe_o,
    // wired-AND sequence line
    input  wire logic                 seq_line_i,
    output logic                      seq_line_o,
    output logic                      seq_line_oe_o,
    // results
    output logic      [3:0]           qual_word_o,
    output logic                      start_store_o,
    output logic                      stop_store_o,
    output logic                      store_gate_o,
    output logic                      alt_trigger_o,
    output logic                      seq_cond_met_o,
    output logic      [3:0]           level_pointer_o
);
    if (P_WORD_W != NUM_SEG * SEG_W || P_NUM_WORDS != NUM_WORDS) begin : g_chk
        $error("twr_top: only a 24-bit word with four qualifier words is supported");
    end

    // byte of the acquired word for a segment
    function automatic logic [7:0] seg_byte(input logic [23:0] w, input int unsigned s);
        seg_byte = w[s*SEG_W +: SEG_W];
    endfunction

    // pick one of four word results
    function automatic logic pick(input logic [3:0] r, input logic [1:0] sel);
        pick = r[sel];
    endfunction

    // storage
    logic [3:0]        qram_q [NUM_SEG][256];
    logic              sram_q [NUM_SEG][4096];
    logic [3:0]        lctl_q [16];

    logic [CTL_W-1:0]  ctl_q;
    logic [ROLE_W-1:0] role_q;
    logic [17:0]       rdsel_q;
    logic              step_prev_q;
    logic [3:0]        qual_oe_q;
    logic              seq_oe_q;
    logic [3:0]        qual_word_q;
    logic              start_q;
    logic              stop_q;
    logic              gate_q;
    logic              alt_q;
    logic              seq_met_q;
    logic [31:0]       rdata_q;

    twr_lvl_if lvl ();

    // register decode
    wire wr_ctl   = reg_we_i & (reg_addr_i == OFS_CTL);
    wire wr_role  = reg_we_i & (reg_addr_i == OFS_ROLE);
    wire wr_qram  = reg_we_i & (reg_addr_i == OFS_QRAM);
    wire wr_sram  = reg_we_i & (reg_addr_i == OFS_SRAM);
    wire wr_lctl  = reg_we_i & (reg_addr_i == OFS_LCTL);
    wire wr_pload = reg_we_i & (reg_addr_i == OFS_PLOAD);
    wire wr_rdsel = reg_we_i & (reg_addr_i == OFS_RDSEL);

    wire [7:0]  qw_addr = reg_wdata_i[7:0];
    wire [1:0]  qw_seg  = reg_wdata_i[QRAM_SEG_LSB +: 2];
    wire [3:0]  qw_data = reg_wdata_i[QRAM_DATA_LSB +: 4];
    wire [11:0] sw_addr = reg_wdata_i[11:0];
    wire [1:0]  sw_seg  = reg_wdata_i[SRAM_SEG_LSB +: 2];
    wire        sw_data = reg_wdata_i[SRAM_DATA_BIT];
    wire [3:0]  lw_lvl  = reg_wdata_i[3:0];
    wire [3:0]  lw_data = reg_wdata_i[LCTL_DATA_LSB +: 4];

    // control bits
    wire [2:0] invert_bits   = ctl_q[CTL_INV_LSB +: 3];
    wire       force_word0   = ctl_q[CTL_FORCE];
    wire       alt_mode      = ctl_q[CTL_ALT_MODE];
    wire       dual_qualify_n = ctl_q[CTL_DUALQ_N];
    wire       step_enable_n = ctl_q[CTL_STEPEN_N];
    wire       host_step_pulse_n = ctl_q[CTL_STEP_N];

    // qualifier lookup: three byte-addressed rams, four columns each
    wire [3:0] segment_a_match = qram_q[0][seg_byte(acquired_word_bus_i, 0)];
    wire [3:0] segment_b_match = qram_q[1][seg_byte(acquired_word_bus_i, 1)];
    wire [3:0] segment_c_match = qram_q[2][seg_byte(acquired_word_bus_i, 2)];
    wire       segment_a_match_word1 = segment_a_match[0];
    wire       segment_b_match_word1 = segment_b_match[0];
    wire       segment_c_match_word1 = segment_c_match[0];
    wire [3:0] local_qual = segment_a_match & segment_b_match & segment_c_match;

    // sequence lookup: pointer selects the level block, byte selects entry
    wire [3:0] level_pointer = lvl.level_pointer;
    wire seq_a = sram_q[0][{level_pointer, seg_byte(acquired_word_bus_i, 0)}];
    wire seq_b = sram_q[1][{level_pointer, seg_byte(acquired_word_bus_i, 1)}];
    wire seq_c = sram_q[2][{level_pointer, seg_byte(acquired_word_bus_i, 2)}];
    wire local_seq = seq_a & seq_b & seq_c;

    // level control
    wire [3:0] lvl_bits          = lctl_q[level_pointer];
    wire       last_level_flag   = lvl_bits[LCTL_LAST_BIT];
    wire       when_polarity_bit = lvl_bits[LCTL_POL_BIT];

    // combined qualifier results after wired-AND
    wire [3:0] word_res = {qual_line_i[3:1] ^ invert_bits, qual_line_i[0] | force_word0};
    wire       reset_word = pick(word_res, role_q[ROLE_RESET +: 2]);

    // sequence recognition; xor output high means no valid word
    wire seq_xor  = seq_line_i ^ when_polarity_bit;
    wire reset_ok = reset_word & seq_xor & ~alt_mode & dual_qualify_n & ~wr_sram;

    // host step on release of the step pulse bit
    wire host_step = ~step_enable_n & host_step_pulse_n & ~step_prev_q;
    wire advance   = step_enable_n ? level_advance_i : host_step;

    assign lvl.clear           = master_reset_i | reset_ok;
    assign lvl.load_n          = ~wr_pload;
    assign lvl.load_val        = reg_wdata_i[3:0];
    assign lvl.advance         = advance;
    assign lvl.last_level_flag = last_level_flag;

    twr_level_ptr u_ptr (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .lvl      (lvl.ptr)
    );

    // readback of ram entries
    wire [1:0] rd_kind = rdsel_q[RDSEL_KIND_LSB +: 2];
    wire [1:0] rd_seg  = rdsel_q[13:12];
    wire [1:0] rd_qseg = (rd_seg == 2'h3) ? 2'h2 : rd_seg;
    wire [3:0] rd_qval = qram_q[rd_qseg][rdsel_q[7:0]];
    wire       rd_sval = sram_q[rd_qseg][rdsel_q[11:0]];
    wire [3:0] rd_lval = lctl_q[rdsel_q[3:0]];
    wire [31:0] rd_ram = (rd_kind == RD_QRAM) ? {28'h0000000, rd_qval} :
                         (rd_kind == RD_SRAM) ? {31'h00000000, rd_sval} :
                         (rd_kind == RD_LCTL) ? {28'h0000000, rd_lval} : 32'h00000000;

    wire [31:0] status = {18'h00000, seq_met_q, alt_q, gate_q, stop_q, start_q,
                          qual_word_q, local_seq, level_pointer};

    wire [31:0] rd_mux = (reg_addr_i == OFS_CTL)    ? {24'h000000, ctl_q} :
                         (reg_addr_i == OFS_ROLE)   ? {22'h000000, role_q} :
                         (reg_addr_i == OFS_LCTL)   ? {28'h0000000, lvl_bits} :
                         (reg_addr_i == OFS_STATUS) ? status :
                         (reg_addr_i == OFS_RDSEL)  ? {14'h0000, rdsel_q} :
                         (reg_addr_i == OFS_RDDATA) ? rd_ram : 32'h00000000;

    // control registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ctl_q       <= CTL_RESET;
            role_q      <= ROLE_RESET_VAL;
            rdsel_q     <= 18'h00000;
            step_prev_q <= 1'b1;
        end else begin
            step_prev_q <= host_step_pulse_n;
            if (wr_ctl) begin
                ctl_q <= reg_wdata_i[CTL_W-1:0];
            end
            if (wr_role) begin
                role_q <= reg_wdata_i[ROLE_W-1:0];
            end
            if (wr_rdsel) begin
                rdsel_q <= reg_wdata_i[17:0];
            end
        end
    end

    // qualifier rams
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            for (int s = 0; s < NUM_SEG; s++) begin
                for (int a = 0; a < 256; a++) begin
                    qram_q[s][a] <= 4'h0;
                end
            end
        end else if (wr_qram && qw_seg != 2'h3) begin
            qram_q[qw_seg][qw_addr] <= qw_data;
        end
    end

    // sequence rams
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            for (int s = 0; s < NUM_SEG; s++) begin
                for (int a = 0; a < 4096; a++) begin
                    sram_q[s][a] <= 1'b0;
                end
            end
        end else if (wr_sram && sw_seg != 2'h3) begin
            sram_q[sw_seg][sw_addr] <= sw_data;
        end
    end

    // level control ram
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            for (int l = 0; l < 16; l++) begin
                lctl_q[l] <= LCTL_RESET;
            end
        end else if (wr_lctl) begin
            lctl_q[lw_lvl] <= lw_data;
        end
    end

    // open-drain pull-downs and results
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            qual_oe_q   <= 4'hF;
            seq_oe_q    <= 1'b1;
            qual_word_q <= 4'h0;
            start_q     <= 1'b0;
            stop_q      <= 1'b0;
            gate_q      <= 1'b0;
            alt_q       <= 1'b0;
            seq_met_q   <= 1'b0;
        end else begin
            qual_oe_q   <= ~local_qual;
            seq_oe_q    <= ~local_seq;
            qual_word_q <= word_res;
            start_q     <= pick(word_res, role_q[ROLE_START +: 2]);
            stop_q      <= pick(word_res, role_q[ROLE_STOP +: 2]);
            gate_q      <= pick(word_res, role_q[ROLE_GATE +: 2]);
            alt_q       <= alt_mode & pick(word_res, role_q[ROLE_ALT +: 2]);
            seq_met_q   <= ~seq_xor;
        end
    end

    // register read port
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= reg_re_i ? rd_mux : 32'h00000000;
        end
    end

    assign reg_rdata_o     = rdata_q;
    assign qual_line_o     = 4'h0;
    assign qual_line_oe_o  = qual_oe_q;
    assign seq_line_o      = 1'b0;
    assign seq_line_oe_o   = seq_oe_q;
    assign qual_word_o     = qual_word_q;
    assign start_store_o   = start_q;
    assign stop_store_o    = stop_q;
    assign store_gate_o    = gate_q;
    assign alt_trigger_o   = alt_q;
    assign seq_cond_met_o  = seq_met_q;
    assign level_pointer_o = level_pointer;
endmodule

// ==== twr_far_model.sv ====
/*
 * twr_far_model: other acquisition modules on the wired-AND lines.
 * assumes pull-up lines and levels set by the bench per module.
 */
`timescale 1ns/100ps
module twr_far_model (
    input  wire logic [3:0] qual_oe_i,
    input  wire logic       seq_oe_i,
    input  wire logic [3:0] other_qual_i,
    input  wire logic       other_seq_i,
    output logic      [3:0] qual_line_o,
    output logic            seq_line_o
);
    // line high only while no module pulls it low
    assign qual_line_o = ~(qual_oe_i | ~other_qual_i);
    assign seq_line_o  = ~(seq_oe_i | ~other_seq_i);
endmodule

// ==== twr_top_props.sv ====
/*
 * twr_top_props: port assertions of the recognizer top.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps
module twr_top_props
    import twr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_we_i,
    input  wire logic        reg_re_i,
    input  wire logic [31:0] reg_rdata_o,
    input  wire logic        level_advance_i,
    input  wire logic        master_reset_i,
    input  wire logic [3:0]  qual_line_i,
    input  wire logic [3:0]  qual_line_o,
    input  wire logic        seq_line_o,
    input  wire logic [3:0]  qual_word_o,
    input  wire logic        alt_trigger_o,
    input  wire logic [3:0]  level_pointer_o
);
    logic [7:0] ctl_q;
    logic       pload_w;
    logic       ctlw_w;
    logic       moved_w;
    assign pload_w = reg_we_i && (reg_addr_i == OFS_PLOAD);
    assign ctlw_w  = reg_we_i && (reg_addr_i == OFS_CTL);
    assign moved_w = level_pointer_o != 4'h0;
    // shadow of the control register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ctl_q <= CTL_RESET;
        end else if (ctlw_w) begin
            ctl_q <= reg_wdata_i[7:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_pointer_clear: assert property (master_reset_i |=> level_pointer_o == LVL_RESET)
        else $error("pointer not cleared by master reset");
    a_pointer_step: assert property ((!$stable(level_pointer_o) && moved_w && !$past(pload_w))
        |-> level_pointer_o == $past(level_pointer_o) + 4'h1)
        else $error("pointer moved by other than one");
    a_advance_cause: assert property ((!$stable(level_pointer_o) && moved_w && !$past(pload_w))
        |-> ($past(level_advance_i) || $past(ctlw_w) || $past(ctlw_w, 2)))
        else $error("pointer advanced without a pulse");
    a_lines_released: assert property (qual_line_o == 4'h0 && !seq_line_o)
        else $error("wired-AND line driven high");
    a_force_word: assert property ($past(resetn_i) |->
        qual_word_o[0] == $past(qual_line_i[0] | ctl_q[CTL_FORCE]))
        else $error("forced word wrong");
    a_invert_words: assert property ($past(resetn_i) |->
        qual_word_o[3:1] == $past(qual_line_i[3:1] ^ ctl_q[2:0]))
        else $error("inverted words wrong");
    a_alt_gated: assert property (alt_trigger_o |-> $past(ctl_q[CTL_ALT_MODE]))
        else $error("alternate trigger without mode");
    a_status_read: assert property ($past(reg_re_i && reg_addr_i == OFS_STATUS)
        |-> {reg_rdata_o[8:5], reg_rdata_o[3:0]} == {$past(qual_word_o), $past(level_pointer_o)})
        else $error("status read wrong");
    c_pointer_top: cover property (level_pointer_o == LVL_MAX);
    c_alt_fired: cover property (alt_trigger_o);
    c_clear_seen: cover property (master_reset_i ##1 level_pointer_o == 4'h0);
endmodule

bind twr_top twr_top_props i_twr_top_props (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .level_advance_i(level_advance_i), .master_reset_i(master_reset_i), .qual_line_i(qual_line_i),
    .qual_line_o(qual_line_o), .seq_line_o(seq_line_o), .qual_word_o(qual_word_o),
    .alt_trigger_o(alt_trigger_o), .level_pointer_o(level_pointer_o));

// ==== twr_top_tb_top.sv ====
/*
 * twr_top_tb_top: register-driven tests of the recognizer.
 * assumes the far model resolves the wired-AND lines.
 */
`timescale 1ns/100ps
module twr_top_tb_top
    import twr_pkg::*;
();
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_we_i = 1'b0;
    logic        reg_re_i = 1'b0;
    logic [23:0] word_q = 24'h0;
    logic        level_advance_i = 1'b0;
    logic        master_reset_i = 1'b0;
    logic [3:0]  other_qual = 4'hF;
    logic        other_seq = 1'b1;
    logic [31:0] reg_rdata_o;
    logic [3:0]  ql_i, ql_o, ql_oe, qual_word_o, lp_o;
    logic        sl_i, sl_o, sl_oe, st_o, sp_o, gt_o, alt_o, cond_o;
    int          failures = 0;
    int          checked = 0;
    int          cycles = 0;
    always #25 clk_i = ~clk_i;
    twr_top i_twr_top (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .acquired_word_bus_i(word_q),
        .level_advance_i(level_advance_i), .master_reset_i(master_reset_i), .qual_line_i(ql_i),
        .qual_line_o(ql_o), .qual_line_oe_o(ql_oe), .seq_line_i(sl_i), .seq_line_o(sl_o),
        .seq_line_oe_o(sl_oe), .qual_word_o(qual_word_o), .start_store_o(st_o), .stop_store_o(sp_o),
        .store_gate_o(gt_o), .alt_trigger_o(alt_o), .seq_cond_met_o(cond_o), .level_pointer_o(lp_o));
    twr_far_model i_twr_far_model (.qual_oe_i(ql_oe), .seq_oe_i(sl_oe), .other_qual_i(other_qual),
        .other_seq_i(other_seq), .qual_line_o(ql_i), .seq_line_o(sl_i));
    task automatic summarize;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wt;
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask
    task automatic qw(input logic [1:0] s, input logic [7:0] a, input logic [3:0] c);
        wr(OFS_QRAM, {18'h0, c, s, a});
    endtask
    task automatic word(input logic [23:0] w);
        @(posedge clk_i);
        word_q <= w;
        wt();
    endtask
    task automatic adv;
        @(posedge clk_i);
        level_advance_i <= 1'b1;
        @(posedge clk_i);
        level_advance_i <= 1'b0;
        wt();
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        logic [31:0] d;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(OFS_STATUS, d);
        chk("status", {19'h0, d[12:0]}, 32'h0);
        rd(8'h40, d);
        chk("unmapped", d, 32'h0);
        // word1 exact, word2 with segment a all don't care
        for (int i = 0; i < 256; i++) qw(2'd0, i[7:0], (i == 8'h56) ? 4'h6 : 4'h4);
        qw(2'd1, 8'h34, 4'h6);
        qw(2'd2, 8'h12, 4'h6);
        word(24'h123456);
        chk("qual_oe", {28'h0, ql_oe}, 32'h9);
        chk("qual", {28'h0, qual_word_o}, 32'h6);
        word(24'h1234AA);
        chk("qual", {28'h0, qual_word_o}, 32'h4);
        word(24'h12FF56);
        chk("qual", {28'h0, qual_word_o}, 32'h0);
        other_qual = 4'hB;
        word(24'h123456);
        chk("qual", {28'h0, qual_word_o}, 32'h2);
        other_qual = 4'hF;
        wr(OFS_CTL, 32'hEF);
        wt();
        chk("qual", {28'h0, qual_word_o}, 32'h9);
        chk("roles", {28'h0, st_o, sp_o, gt_o, alt_o}, 32'hE);
        wr(OFS_CTL, 32'hF0);
        wr(OFS_ROLE, 32'h1F9);
        wt();
        chk("roles", {28'h0, st_o, sp_o, gt_o, alt_o}, 32'hD);
        word(24'h1234AA);
        chk("roles", {28'h0, st_o, sp_o, gt_o, alt_o}, 32'h4);
        wr(OFS_CTL, 32'hE0);
        word(24'h123456);
        chk("roles", {28'h0, st_o, sp_o, gt_o, alt_o}, 32'hC);
        // level 1 segment matches the word, level 0 does not
        for (int s = 0; s < 3; s++) wr(OFS_SRAM, {15'h0, 1'b1, 2'b0, s[1:0], 4'h1, word_q[8*s+:8]});
        wt();
        chk("seq_oe", {31'h0, sl_oe}, 32'h1);
        adv();
        chk("pointer", {28'h0, lp_o}, 32'h1);
        chk("seq_oe", {31'h0, sl_oe}, 32'h0);
        chk("cond", {31'h0, cond_o}, 32'h0);
        wr(OFS_LCTL, 32'h91);
        wt();
        chk("cond", {31'h0, cond_o}, 32'h1);
        rd(OFS_LCTL, d);
        chk("lctl", d, 32'h9);
        other_seq = 1'b0;
        wr(OFS_CTL, 32'hF0);
        wr(OFS_ROLE, 32'h179);
        wt();
        chk("cond", {31'h0, cond_o}, 32'h0);
        chk("pointer", {28'h0, lp_o}, 32'h1);
        wr(OFS_CTL, 32'hC0);
        wt();
        chk("pointer", {28'h0, lp_o}, 32'h1);
        wr(OFS_CTL, 32'hE0);
        wt();
        chk("pointer", {28'h0, lp_o}, 32'h0);
        wr(OFS_ROLE, 32'h1F9);
        other_seq = 1'b1;
        wr(OFS_CTL, 32'h20);
        wr(OFS_CTL, 32'hA0);
        wt();
        chk("pointer", {28'h0, lp_o}, 32'h1);
        adv();
        chk("pointer", {28'h0, lp_o}, 32'h1);
        wr(OFS_CTL, 32'hE0);
        wr(OFS_LCTL, 32'h01);
        adv();
        chk("pointer", {28'h0, lp_o}, 32'h1);
        wr(OFS_PLOAD, 32'hE);
        wt();
        chk("pointer", {28'h0, lp_o}, 32'hE);
        adv();
        adv();
        chk("pointer", {28'h0, lp_o}, 32'hF);
        wr(OFS_RDSEL, {14'h0, RD_LCTL, 16'h000F});
        rd(OFS_RDDATA, d);
        chk("lctl_reset", d, {28'h0, LCTL_RESET});
        rd(OFS_STATUS, d);
        chk("status", d, 32'h26CF);
        @(posedge clk_i);
        master_reset_i <= 1'b1;
        @(posedge clk_i);
        master_reset_i <= 1'b0;
        wt();
        chk("pointer", {28'h0, lp_o}, 32'h0);
        summarize();
    end
endmodule
